// file: logic/tsc_touch_ctrl.sv
// Touch sampling scheduler, recalibration control and interrupt gating with AHB-Lite registers.
//
// Function
// - Sample count per channel is 1 to 128, chosen by config bits 6..4.
// - All samples of a channel run back to back, then averaged and stored.
// - One sample lasts 320 us, 640 us, 1.28 ms or 2.56 ms by bits 3..2.
// - Cycle period is 35, 70, 105 or 140 ms by bits 1..0.
// - Channels are sampled at cycle start, the rest of the period is idle.
// - If sampling overruns the period, the cycle stretches until it finishes.
// - The configuration governs sampling only while the active power state holds.
// - Writing one to a request bit recalibrates that channel.
// - During recalibration, presses are not reported and base count is invalid.
// - A press during recalibration invalidates it and restarts the wait.
// - Completed recalibration updates that channel's 10-bit calibration result.
// - Hardware clears the request bit once recalibration succeeds.
// - Request bit 7 is channel 8 down to bit 0 for channel 1.
// - A touch raises the interrupt only when that channel's enable is one.
// - The channel enable gates release interrupts too.
// - Only enabled channels are sampled; period does not depend on their number.
// - Release suppress clear: press and release interrupt; set: press only.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "tsc_defines.svh"
module tsc_touch_ctrl #(
   parameter logic [23:0] SAMPLE_BASE_CYC = 24'(`TSC_SAMPLE_BASE_CYC),
   parameter logic [23:0] CYCLE_BASE_CYC = 24'(`TSC_CYCLE_BASE_CYC),
   parameter logic [23:0] CAL_CYC = 24'(`TSC_CAL_MAX_CYC),
   parameter int CHANNELS = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic active_state,
   input wire logic [CHANNELS-1:0] touch_input,
   input wire logic [15:0] sample_value,
   input wire logic [9:0] cal_value,
   output logic sensing,
   output logic [2:0] sense_channel,
   output logic low_power_idle,
   output logic result_valid,
   output logic [2:0] result_channel,
   output logic [15:0] result_value,
   output logic [CHANNELS-1:0] base_count_invalid,
   output logic [CHANNELS-1:0] touch_report,
   output logic touch_irq
);

   // -------------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------------
   // First enabled channel at or above 'from'.
   function automatic tsc_pkg::tsc_ch_pick_t pick_channel(input logic [7:0] en,
                                                         input logic [3:0] from);
      tsc_pkg::tsc_ch_pick_t p;
      p = '0;
      for (int i = 7; i >= 0; i--)
      begin
         if (en[i] && (4'(i) >= from))
         begin
            p.found = 1'b1;
            p.ch = 3'(i);
         end
      end
      return p;
   endfunction : pick_channel

   function automatic logic [23:0] period_cycles(input logic [1:0] code);
      logic [23:0] c;
      case (code)
         2'h0: c = CYCLE_BASE_CYC;
         2'h1: c = CYCLE_BASE_CYC << 1;
         2'h2: c = CYCLE_BASE_CYC + (CYCLE_BASE_CYC << 1);
         default: c = CYCLE_BASE_CYC << 2;
      endcase
      return c;
   endfunction : period_cycles

   // -------------------------------------------------------------------------
   // Pin synchronisation and recalibration channels
   // -------------------------------------------------------------------------
   logic [CHANNELS-1:0] touch_level;
   logic [CHANNELS-1:0] touch_rise;
   logic [CHANNELS-1:0] touch_fall;
   logic [CHANNELS-1:0] cal_busy;
   logic [CHANNELS-1:0] cal_done;
   logic [9:0] cal_result [CHANNELS];
   logic [7:0] recal_q, recal_d;

   tsc_pin_sync #(
      .WIDTH(CHANNELS)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(touch_input),
      .level(touch_level),
      .rise(touch_rise),
      .fall(touch_fall)
   );

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_cal
         tsc_recal_channel #(
            .CAL_CYC(CAL_CYC)
         ) u_cal (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .request(recal_q[g]),
            .press(touch_level[g]),
            .cal_value(cal_value),
            .busy(cal_busy[g]),
            .done(cal_done[g]),
            .result(cal_result[g])
         );
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Register file and AHB-Lite slave
   // -------------------------------------------------------------------------
   logic [7:0] samp_en_q, samp_en_d;
   logic [7:0] cfg_q, cfg_d;
   logic [7:0] ien_q, ien_d;
   logic [7:0] ctrl_q, ctrl_d;
   tsc_pkg::tsc_bus_req_t dph_q, dph_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [15:0] meas_mem [CHANNELS];
   tsc_pkg::tsc_seq_state_t state_q;

   function automatic logic [31:0] read_reg(input logic [7:0] idx);
      logic [31:0] r;
      r = '0;
      if ((idx & `TSC_IDX_WINDOW_MASK) == `TSC_IDX_CALRES_BASE)
         r = {22'h000000, cal_result[idx[2:0]]};
      else if ((idx & `TSC_IDX_WINDOW_MASK) == `TSC_IDX_RESULT_BASE)
         r = {16'h0000, meas_mem[idx[2:0]]};
      else
      begin
         case (idx)
            `TSC_IDX_SAMPLE_EN: r = {24'h000000, samp_en_q};
            `TSC_IDX_AVG_CFG: r = {24'h000000, cfg_q};
            `TSC_IDX_RECAL: r = {24'h000000, recal_q};
            `TSC_IDX_IEN: r = {24'h000000, ien_q};
            `TSC_IDX_CTRL: r = {24'h000000, ctrl_q};
            `TSC_IDX_STATUS: r = {8'h00, cal_busy, touch_level, 6'h00,
                                  state_q == tsc_pkg::SEQ_WAIT,
                                  state_q == tsc_pkg::SEQ_SAMPLE};
            default: r = '0;
         endcase
      end
      return r;
   endfunction : read_reg

   logic wr_now;
   assign wr_now = dph_q.valid && dph_q.write;

   // Zero wait states: read data is fetched in the address phase, so it
   // stands registered through the whole data phase.
   always_comb
   begin
      dph_d = '0;
      hrdata_d = hrdata_q;
      if (hsel && hready && htrans[1])
      begin
         dph_d.valid = 1'b1;
         dph_d.write = hwrite;
         dph_d.idx = haddr[9:2];
         if (!hwrite)
            hrdata_d = read_reg(haddr[9:2]);
      end
      samp_en_d = samp_en_q;
      cfg_d = cfg_q;
      ien_d = ien_q;
      ctrl_d = ctrl_q;
      // A software set wins over a completion clear in the same cycle.
      recal_d = recal_q & ~cal_done;
      if (wr_now)
      begin
         case (dph_q.idx)
            `TSC_IDX_SAMPLE_EN: samp_en_d = hwdata[7:0];
            `TSC_IDX_AVG_CFG: cfg_d = hwdata[7:0] & `TSC_AVG_CFG_MASK;
            `TSC_IDX_RECAL: recal_d = recal_d | hwdata[7:0];
            `TSC_IDX_IEN: ien_d = hwdata[7:0];
            `TSC_IDX_CTRL: ctrl_d = {7'h00, hwdata[`TSC_CTRL_REL_SUPPRESS]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dph_q <= '0;
         hrdata_q <= '0;
         samp_en_q <= `TSC_SAMPLE_EN_RST;
         cfg_q <= `TSC_AVG_CFG_RST;
         recal_q <= `TSC_RECAL_RST;
         ien_q <= `TSC_IEN_RST;
         ctrl_q <= `TSC_CTRL_RST;
      end
      else
      begin
         dph_q <= dph_d;
         hrdata_q <= hrdata_d;
         samp_en_q <= samp_en_d;
         cfg_q <= cfg_d;
         recal_q <= recal_d;
         ien_q <= ien_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // -------------------------------------------------------------------------
   // Sampling sequencer
   // -------------------------------------------------------------------------
   tsc_pkg::tsc_seq_state_t state_d;
   tsc_pkg::tsc_cfg_t lat_q, lat_d;
   tsc_pkg::tsc_ch_pick_t pick;
   logic [7:0] en_lat_q, en_lat_d;
   logic [2:0] ch_q, ch_d;
   logic [7:0] smp_q, smp_d;
   logic [23:0] win_q, win_d;
   logic [23:0] per_q, per_d;
   logic [23:0] acc_q, acc_d;
   logic [23:0] sum;
   logic [23:0] per_last;
   logic [23:0] win_last;
   logic [7:0] smp_last;
   logic res_we_d;
   logic [15:0] res_val_d;
   logic cycle_start;

   // Settings are latched at cycle start so a write mid-cycle cannot mix
   // two sample counts inside one channel's average.
   assign per_last = period_cycles(lat_q.cycle_select) - 24'h000001;
   assign win_last = (SAMPLE_BASE_CYC << lat_q.per_sample_duration) - 24'h000001;
   assign smp_last = (8'h01 << lat_q.sample_count_select) - 8'h01;
   assign sum = acc_q + {8'h00, sample_value};

   always_comb
   begin
      state_d = state_q;
      lat_d = lat_q;
      en_lat_d = en_lat_q;
      ch_d = ch_q;
      smp_d = smp_q;
      win_d = win_q;
      acc_d = acc_q;
      res_we_d = 1'b0;
      res_val_d = '0;
      cycle_start = 1'b0;
      pick = '0;
      // The period counter runs on its own, so its length never depends on
      // which channels take part; it holds at its end while sampling overruns.
      per_d = (per_q == per_last) ? per_q : per_q + 24'h000001;
      case (state_q)
         tsc_pkg::SEQ_OFF:
         begin
            if (active_state)
               cycle_start = 1'b1;
         end
         tsc_pkg::SEQ_SAMPLE:
         begin
            if (win_q != win_last)
               win_d = win_q + 24'h000001;
            else
            begin
               win_d = '0;
               acc_d = sum;
               smp_d = smp_q + 8'h01;
               if (smp_q == smp_last)
               begin
                  res_we_d = 1'b1;
                  res_val_d = 16'(sum >> lat_q.sample_count_select);
                  acc_d = '0;
                  smp_d = '0;
                  pick = pick_channel(en_lat_q, {1'b0, ch_q} + 4'h1);
                  if (pick.found)
                     ch_d = pick.ch;
                  else if (per_q == per_last)
                     cycle_start = 1'b1;
                  else
                     state_d = tsc_pkg::SEQ_WAIT;
               end
            end
         end
         tsc_pkg::SEQ_WAIT:
         begin
            if (per_q == per_last)
               cycle_start = 1'b1;
         end
         default: state_d = tsc_pkg::SEQ_OFF;
      endcase
      if (cycle_start)
      begin
         lat_d = cfg_q[6:0];
         en_lat_d = samp_en_q;
         per_d = '0;
         win_d = '0;
         smp_d = '0;
         acc_d = '0;
         pick = pick_channel(samp_en_q, 4'h0);
         ch_d = pick.ch;
         state_d = pick.found ? tsc_pkg::SEQ_SAMPLE : tsc_pkg::SEQ_WAIT;
      end
      if (!active_state)
      begin
         state_d = tsc_pkg::SEQ_OFF;
         res_we_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= tsc_pkg::SEQ_OFF;
         lat_q <= 7'(`TSC_AVG_CFG_RST);
         en_lat_q <= `TSC_SAMPLE_EN_RST;
         ch_q <= '0;
         smp_q <= '0;
         win_q <= '0;
         per_q <= '0;
         acc_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         lat_q <= lat_d;
         en_lat_q <= en_lat_d;
         ch_q <= ch_d;
         smp_q <= smp_d;
         win_q <= win_d;
         per_q <= per_d;
         acc_q <= acc_d;
      end
   end

   // Measured results are kept per channel for readback.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
            meas_mem[i] <= '0;
      end
      else if (res_we_d)
      begin
         meas_mem[ch_q] <= res_val_d;
      end
   end

   // -------------------------------------------------------------------------
   // Touch reporting and interrupt gating
   // -------------------------------------------------------------------------
   logic [7:0] press_ev;
   logic [7:0] release_ev;
   logic irq_d;

   always_comb
   begin
      press_ev = touch_rise & ~cal_busy & ien_q;
      release_ev = touch_fall & ~cal_busy & ien_q;
      irq_d = (|press_ev) ||
              ((|release_ev) && !ctrl_q[`TSC_CTRL_REL_SUPPRESS]);
   end

   logic sensing_q;
   logic [2:0] sense_ch_q;
   logic low_power_q;
   logic res_valid_q;
   logic [2:0] res_ch_q;
   logic [15:0] res_val_q;
   logic [7:0] base_inv_q;
   logic [7:0] report_q;
   logic irq_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sensing_q <= 1'b0;
         sense_ch_q <= '0;
         low_power_q <= 1'b0;
         res_valid_q <= 1'b0;
         res_ch_q <= '0;
         res_val_q <= '0;
         base_inv_q <= '0;
         report_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         sensing_q <= state_d == tsc_pkg::SEQ_SAMPLE;
         sense_ch_q <= ch_d;
         low_power_q <= state_d == tsc_pkg::SEQ_WAIT;
         res_valid_q <= res_we_d;
         res_ch_q <= ch_q;
         res_val_q <= res_val_d;
         base_inv_q <= cal_busy;
         report_q <= touch_level & ~cal_busy;
         irq_q <= irq_d;
      end
   end

   assign sensing = sensing_q;
   assign sense_channel = sense_ch_q;
   assign low_power_idle = low_power_q;
   assign result_valid = res_valid_q;
   assign result_channel = res_ch_q;
   assign result_value = res_val_q;
   assign base_count_invalid = base_inv_q;
   assign touch_report = report_q;
   assign touch_irq = irq_q;

endmodule : tsc_touch_ctrl

// file: common/tsc_defines.svh
// Register indices, field positions, reset values and timing constants of the touch controller.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define TSC_IDX_SAMPLE_EN 8'h21
`define TSC_IDX_AVG_CFG 8'h24
`define TSC_IDX_RECAL 8'h26
`define TSC_IDX_IEN 8'h27
`define TSC_IDX_CTRL 8'h30
`define TSC_IDX_STATUS 8'h31
`define TSC_IDX_CALRES_BASE 8'h40
`define TSC_IDX_RESULT_BASE 8'h48
`define TSC_IDX_WINDOW_MASK 8'hf8

// ----------------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------------
`define TSC_SAMPLE_EN_RST 8'hff
`define TSC_AVG_CFG_RST 8'h39
`define TSC_AVG_CFG_MASK 8'h7f
`define TSC_RECAL_RST 8'h00
`define TSC_IEN_RST 8'hff
`define TSC_CTRL_RST 8'h00
`define TSC_CTRL_REL_SUPPRESS 0
`define TSC_AVG_MSB 6
`define TSC_AVG_LSB 4
`define TSC_SAMP_MSB 3
`define TSC_SAMP_LSB 2
`define TSC_CYC_MSB 1
`define TSC_CYC_LSB 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TSC_CLK_HZ 10000000
`define TSC_SAMPLE_BASE_US 320
`define TSC_CYCLE_BASE_MS 35
`define TSC_CAL_MAX_MS 600
`define TSC_SAMPLE_BASE_CYC (`TSC_SAMPLE_BASE_US * (`TSC_CLK_HZ / 1000000))
`define TSC_CYCLE_BASE_CYC (`TSC_CYCLE_BASE_MS * (`TSC_CLK_HZ / 1000))
`define TSC_CAL_MAX_CYC (`TSC_CAL_MAX_MS * (`TSC_CLK_HZ / 1000))

`endif

// file: common/tsc_pkg.sv
// Types shared by the touch sampling and calibration controller.
package tsc_pkg;

   typedef enum logic [1:0] {
      SEQ_OFF,
      SEQ_SAMPLE,
      SEQ_WAIT
   } tsc_seq_state_t;

   typedef struct packed {
      logic [2:0] sample_count_select;
      logic [1:0] per_sample_duration;
      logic [1:0] cycle_select;
   } tsc_cfg_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] idx;
   } tsc_bus_req_t;

   typedef struct packed {
      logic found;
      logic [2:0] ch;
   } tsc_ch_pick_t;

endpackage : tsc_pkg

// file: logic/tsc_pin_sync.sv
// Two-stage synchroniser with press and release edge detection for touch pins.
`timescale 1ns/10ps
module tsc_pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   // The edge detector only looks at the second stage and its delayed copy.
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   always_comb
   begin
      level = sync_q;
      rise = sync_q & ~prev_q;
      fall = ~sync_q & prev_q;
   end

endmodule : tsc_pin_sync

// file: logic/tsc_recal_channel.sv
// Recalibration timer and result holder for one touch channel.
`timescale 1ns/10ps
`include "tsc_defines.svh"
module tsc_recal_channel #(
   parameter logic [23:0] CAL_CYC = 24'(`TSC_CAL_MAX_CYC)
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic request,
   input wire logic press,
   input wire logic [9:0] cal_value,
   output logic busy,
   output logic done,
   output logic [9:0] result
);

   logic busy_q, busy_d;
   logic done_q, done_d;
   logic [23:0] cnt_q, cnt_d;
   logic [9:0] result_q, result_d;

   // done_q blocks a restart in the cycle before the request bit falls.
   always_comb
   begin
      busy_d = busy_q;
      done_d = 1'b0;
      cnt_d = cnt_q;
      result_d = result_q;
      if (!busy_q)
      begin
         if (request && !done_q)
         begin
            busy_d = 1'b1;
            cnt_d = '0;
         end
      end
      else if (press)
      begin
         cnt_d = '0;
      end
      else if (cnt_q == CAL_CYC - 24'h000001)
      begin
         busy_d = 1'b0;
         done_d = 1'b1;
         result_d = cal_value;
      end
      else
      begin
         cnt_d = cnt_q + 24'h000001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= '0;
         result_q <= '0;
      end
      else
      begin
         busy_q <= busy_d;
         done_q <= done_d;
         cnt_q <= cnt_d;
         result_q <= result_d;
      end
   end

   assign busy = busy_q;
   assign done = done_q;
   assign result = result_q;

endmodule : tsc_recal_channel

// file: verification/tsc_touch_ctrl_assertions.sv
// Port-level assertions for the touch sampling controller.
`timescale 1ns/10ps
module tsc_touch_ctrl_assertions #(
   parameter int CHANNELS = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic active_state,
   input wire logic sensing,
   input wire logic [2:0] sense_channel,
   input wire logic low_power_idle,
   input wire logic result_valid,
   input wire logic [2:0] result_channel,
   input wire logic [CHANNELS-1:0] base_count_invalid,
   input wire logic [CHANNELS-1:0] touch_report
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("Bus slave stalled or erred.");
   a_sense_idle_apart: assert property (!(sensing && low_power_idle))
      else $error("Sampling and idle overlap.");
   a_start_on_active: assert property ($rose(active_state) |-> ##[1:3] (sensing || low_power_idle))
      else $error("No cycle start after activation.");
   a_stop_inactive: assert property (!active_state [*2] |=> !sensing && !low_power_idle)
      else $error("Sequencer runs while inactive.");
   a_result_pulse: assert property (result_valid |=> !result_valid)
      else $error("Result strobe longer than one cycle.");
   a_result_after_sense: assert property (result_valid |-> $past(sensing) || $past(sensing, 2))
      else $error("Result without sampling.");
   a_result_channel: assert property (result_valid |-> result_channel == $past(sense_channel) ||
      result_channel == $past(sense_channel, 2))
      else $error("Result tagged with wrong channel.");
   a_recal_masks: assert property ((base_count_invalid & $past(base_count_invalid) & touch_report) == '0)
      else $error("Touch reported during recalibration.");
endmodule : tsc_touch_ctrl_assertions

bind tsc_touch_ctrl tsc_touch_ctrl_assertions #(
   .CHANNELS(CHANNELS)
) i_tsc_touch_ctrl_assertions (
   .clk_sys(clk_sys),
   .rst_n(rst_n),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .active_state(active_state),
   .sensing(sensing),
   .sense_channel(sense_channel),
   .low_power_idle(low_power_idle),
   .result_valid(result_valid),
   .result_channel(result_channel),
   .base_count_invalid(base_count_invalid),
   .touch_report(touch_report)
);

// file: verification/tsc_analog_model.sv
// Analog front end stand-in: touch pads, sample and calibration values.
`timescale 1ns/10ps
module tsc_analog_model #(
   parameter logic [15:0] SAMPLE = 16'h0123,
   parameter logic [9:0] CAL = 10'h2a5
) (
   input wire logic [7:0] pad_press,
   output logic [7:0] touch_input,
   output logic [15:0] sample_value,
   output logic [9:0] cal_value
);
   // A steady level makes every correct average equal the level itself.
   assign touch_input = pad_press;
   assign sample_value = SAMPLE;
   assign cal_value = CAL;
endmodule : tsc_analog_model

// file: verification/tsc_touch_ctrl_bench.sv
// Self-checking bench for the touch sampling and calibration controller.
`timescale 1ns/10ps
`include "tsc_defines.svh"
module tsc_touch_ctrl_bench;
   localparam logic [15:0] SAMPLE = 16'h0123;
   localparam logic [9:0] CAL = 10'h2a5;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic active_state = 1'b0;
   logic [7:0] pad_press = 8'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, sensing, low_power_idle, result_valid, touch_irq, idle_seen;
   logic [2:0] sense_channel, result_channel;
   logic [15:0] sample_value, result_value;
   logic [9:0] cal_value;
   logic [7:0] touch_input, base_count_invalid, touch_report, seen;
   logic [7:0] cfgs [8] = '{8'h0c, 8'h11, 8'h26, 8'h3b, 8'h40, 8'h50, 8'h60, 8'h70};
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int irqs = 0;

   initial
   begin
      forever #50 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (touch_irq === 1'b1)
         irqs <= irqs + 1;
   end

   tsc_analog_model #(.SAMPLE(SAMPLE), .CAL(CAL)) i_tsc_analog_model (.pad_press(pad_press),
      .touch_input(touch_input), .sample_value(sample_value), .cal_value(cal_value));

   tsc_touch_ctrl #(.SAMPLE_BASE_CYC(24'h4), .CYCLE_BASE_CYC(24'hc8), .CAL_CYC(24'h14))
   i_tsc_touch_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .active_state(active_state),
      .touch_input(touch_input), .sample_value(sample_value), .cal_value(cal_value),
      .sensing(sensing), .sense_channel(sense_channel), .low_power_idle(low_power_idle),
      .result_valid(result_valid), .result_channel(result_channel),
      .result_value(result_value), .base_count_invalid(base_count_invalid),
      .touch_report(touch_report), .touch_irq(touch_irq));

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Starting one edge late leaves the IDLE a read-after-write needs.
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk_sys);
      haddr <= {22'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      bus(1'b1, idx, {24'h0, d}, rd);
   endtask : wr

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0, rd);
      chk(rd, exp, what);
   endtask : rdc

   task automatic next_res(input logic [2:0] ch, output int t);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (!(result_valid === 1'b1 && result_channel === ch) && n < 3000)
      begin
         if (result_valid === 1'b1)
            seen[result_channel] = 1'b1;
         if (low_power_idle === 1'b1)
            idle_seen = 1'b1;
         @(negedge clk_sys);
         n++;
      end
      chk(n < 3000, 1, "wait");
      seen[ch] = 1'b1;
      t = cyc;
   endtask : next_res

   task automatic tog(input int ch);
      @(posedge clk_sys);
      pad_press[ch] <= ~pad_press[ch];
      repeat (8) @(negedge clk_sys);
   endtask : tog

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      rdc(`TSC_IDX_AVG_CFG, 32'h39, "cfg reset");
      rdc(`TSC_IDX_RECAL, 32'h0, "recal reset");
      rdc(`TSC_IDX_IEN, 32'hff, "ien reset");
      rdc(8'h3f, 32'h0, "unmapped");
      wr(`TSC_IDX_AVG_CFG, 8'hff);
      rdc(`TSC_IDX_AVG_CFG, 32'h7f, "cfg bits");
   endtask : t_regs

   task automatic t_cycle();
      int t0, t1, t2, n, p;
      wr(`TSC_IDX_SAMPLE_EN, 8'h05);
      foreach (cfgs[i])
      begin
         n = (1 << cfgs[i][6:4]) * (4 << cfgs[i][3:2]);
         p = 200 * (cfgs[i][1:0] + 1);
         wr(`TSC_IDX_AVG_CFG, cfgs[i]);
         active_state <= 1'b1;
         next_res(3'h2, t0);
         next_res(3'h0, t0);
         chk({16'h0, result_value}, {16'h0, SAMPLE}, "average");
         seen = 8'h0;
         idle_seen = 1'b0;
         next_res(3'h2, t2);
         next_res(3'h0, t1);
         chk(t2 - t0, n, "sample span");
         if (2 * n < p)
            chk(t1 - t0, p, "period");
         else
            chk(t1 - t0, 2 * n, "stretch");
         chk(idle_seen, 2 * n < p, "idle");
         chk(seen, 8'h05, "channels");
      end
      @(posedge clk_sys);
      active_state <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(sensing | low_power_idle, 0, "inactive");
   endtask : t_cycle

   task automatic t_recal();
      int t0, n0;
      logic [31:0] rd;
      wr(`TSC_IDX_RECAL, 8'h00);
      rdc(`TSC_IDX_RECAL, 32'h0, "zero write");
      wr(`TSC_IDX_RECAL, 8'h80);
      repeat (3) @(negedge clk_sys);
      chk({24'h0, base_count_invalid}, 32'h80, "busy");
      n0 = irqs;
      tog(7);
      t0 = cyc;
      tog(7);
      chk(irqs - n0, 0, "press hidden");
      rd = 32'h80;
      while (rd !== 32'h0 && cyc - t0 < 200)
         bus(1'b0, `TSC_IDX_RECAL, 32'h0, rd);
      chk(rd, 32'h0, "cleared");
      chk(cyc - t0 >= 20, 1, "restart");
      rdc(`TSC_IDX_CALRES_BASE + 8'h07, {22'h0, CAL}, "cal ch8");
      rdc(`TSC_IDX_CALRES_BASE, 32'h0, "cal ch1");
   endtask : t_recal

   task automatic t_irq();
      int n0;
      wr(`TSC_IDX_IEN, 8'h01);
      wr(`TSC_IDX_CTRL, 8'h00);
      n0 = irqs;
      tog(1);
      tog(1);
      chk(irqs - n0, 0, "gated");
      tog(0);
      chk({24'h0, touch_report}, 32'h01, "report");
      chk(irqs - n0, 1, "press irq");
      tog(0);
      chk(irqs - n0, 2, "release irq");
      wr(`TSC_IDX_CTRL, 8'h01);
      tog(0);
      tog(0);
      chk(irqs - n0, 3, "release off");
   endtask : t_irq

   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_regs();
      t_cycle();
      t_recal();
      t_irq();
      summarize();
   end

   initial
   begin
      repeat (40000) @(posedge clk_sys);
      fail_count++;
      $display("FAIL %0t watchdog expired", $time);
      summarize();
   end
endmodule : tsc_touch_ctrl_bench
